// [design/isc_pkg.sv]
package isc_pkg;

    localparam int ISC_DATA_W = 32;

    // Register byte offsets
    localparam logic [15:0] ISC_OFS_POL = 16'h3000;
    localparam logic [15:0] ISC_OFS_CLR = 16'h3004;
    localparam logic [15:0] ISC_OFS_EN0 = 16'h3008;
    localparam logic [15:0] ISC_OFS_EN1 = 16'h300c;
    localparam logic [15:0] ISC_OFS_FLG0 = 16'h3010;
    localparam logic [15:0] ISC_OFS_FLG1 = 16'h3014;
    localparam logic [15:0] ISC_OFS_GEN = 16'h209c;

    // Field positions
    localparam int ISC_POL_BIT = 0;
    localparam int ISC_CUSTOM_LSB = 9;
    localparam int ISC_CUSTOM_N = 4;

    // Values after reset
    localparam logic [31:0] ISC_POL_RESET = 32'h0000_0000;
    localparam logic [31:0] ISC_CLR_RESET = 32'h0000_0000;
    localparam logic [31:0] ISC_EN_RESET = 32'h0000_2000;
    localparam logic [31:0] ISC_FLAG_RESET = 32'h0000_0000;
    // Falling-edge sense with no flag leaves the pin high
    localparam logic ISC_IRQ_RESET = 1'b1;

    // Implemented source bits: 0-13, 15-17, 23-27, 29, 31
    localparam logic [31:0] ISC_SRC_MASK = 32'haf83_bfff;
    localparam logic [31:0] ISC_CUSTOM_MASK = 32'h0000_1e00;

    localparam logic [1:0] ISC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ISC_RESP_SLVERR = 2'h2;

    typedef enum {
        ISC_REG_POL,
        ISC_REG_CLR,
        ISC_REG_EN0,
        ISC_REG_EN1,
        ISC_REG_FLG0,
        ISC_REG_FLG1,
        ISC_REG_GEN,
        ISC_REG_NONE
    } isc_reg_t;

    function automatic logic [31:0] isc_strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

endpackage

// [design/isc_irq_channel.sv]
`timescale 1ns/10ps
module isc_irq_channel
    import isc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic en_wr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic [3:0] wr_strb_in,
    input wire logic [31:0] clr_in,
    input wire logic [31:0] src_in,
    input wire logic pol_in,
    output logic [31:0] enable_out,
    output logic [31:0] flags_out,
    output logic irq_out
);

    typedef struct packed {
        logic [31:0] en;
        logic [31:0] flags;
        logic irq;
    } isc_chan_state_t;

    isc_chan_state_t st;
    isc_chan_state_t next_st;

    always_comb begin
        logic [31:0] m;
        m = isc_strb_mask(wr_strb_in) & ISC_SRC_MASK;
        next_st = st;
        if (en_wr_in) begin
            next_st.en = (st.en & ~m) | (wr_data_in & m);
        end
        next_st.flags = (st.flags & ~clr_in) | (src_in & st.en);
        next_st.irq = pol_in ? (|next_st.flags) : ~(|next_st.flags);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st <= '{en: ISC_EN_RESET, flags: ISC_FLAG_RESET, irq: ISC_IRQ_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign enable_out = st.en;
    assign flags_out = st.flags;
    assign irq_out = st.irq;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_idle_then_flag(logic p);
        // Polarity must have settled a cycle before the pin can follow it
        (pol_in == p && flags_out == 32'h0)[*2] ##1 (pol_in == p && flags_out != 32'h0);
    endsequence

    AST_SET_WINS: assert property (((src_in & enable_out) != 32'h0) |=>
        ((flags_out & $past(src_in & enable_out)) == $past(src_in & enable_out)))
        else $error("enabled event did not set its flag");
    AST_CLEAR: assert property (((clr_in & ~(src_in & enable_out)) != 32'h0) |=>
        ((flags_out & $past(clr_in & ~(src_in & enable_out))) == 32'h0))
        else $error("cleared flag still set");
    AST_DISABLED_QUIET: assert property (1'b1 |=>
        ((flags_out & ~$past(flags_out) & ~$past(enable_out)) == 32'h0))
        else $error("disabled source set a flag");
    AST_EN_RESERVED: assert property ((enable_out & ~ISC_SRC_MASK) == 32'h0)
        else $error("reserved enable bit set");
    AST_EN_RESET: assert property ($rose(rst_n_in) |-> enable_out == ISC_EN_RESET)
        else $error("enable register reset value wrong");
    AST_PIN_RISE: assert property (s_idle_then_flag(1'b1) |-> $rose(irq_out))
        else $error("no rising edge on pin");
    AST_PIN_FALL: assert property (s_idle_then_flag(1'b0) |-> $fell(irq_out))
        else $error("no falling edge on pin");

endmodule

// [design/isc_irq_ctrl.sv]
`timescale 1ns/10ps
// What this block does
// - Polarity bit 0 picks edge, resets 0
// - Clear bits 0-3 clear result flags
// - Clear bits 4-6 clear ADC fail flags
// - Clear bits 7, 8 clear mean, variance
// - Clear bits 9-12 clear custom flags
// - Clear bits 13, 15 clear boot, sequence-end
// - Clear bits 16, 17 clear timeout flags
// - Clear bits 23-27 clear buffer flags
// - Bits 29, 31 clear; register write-only
// - Two enable registers; bits 31, 29
// - Enable bits 23-27 gate buffer sources
// - Enable bits 15-17 gate sequencer sources
// - Enable bit 13 boot, resets to 1
// - Enable bits 9-12 gate custom sources
// - Enable bits 4-8 gate fail, statistics
// - Enable bits 0-3 gate result sources
// - Enabled event sets that output's flag
// - Flag toggles pin with programmed edge
// - Polarity, clear shared; enable, flags per output
// - Custom events only from sequencer, host ignored
module isc_irq_ctrl
    import isc_pkg::*;
#(
    parameter int ADDR_W = 16
)(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Source event pulses, one bit per flag position
    input wire logic [31:0] events_in,
    // Sequencer write to the analog generation interrupt register
    input wire logic seq_gen_wr_in,
    input wire logic [3:0] seq_gen_data_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic irq_output_0_out,
    output logic irq_output_1_out
);

    if (ADDR_W < 16) begin : g_addr_check
        $error("ADDR_W must be at least 16");
    end

    typedef struct packed {
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic pol;
    } isc_top_state_t;

    isc_top_state_t st;
    isc_top_state_t next_st;

    function automatic isc_reg_t decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = {a[ADDR_W-1:2], 2'b00};
        case (w)
            ADDR_W'(ISC_OFS_POL): return ISC_REG_POL;
            ADDR_W'(ISC_OFS_CLR): return ISC_REG_CLR;
            ADDR_W'(ISC_OFS_EN0): return ISC_REG_EN0;
            ADDR_W'(ISC_OFS_EN1): return ISC_REG_EN1;
            ADDR_W'(ISC_OFS_FLG0): return ISC_REG_FLG0;
            ADDR_W'(ISC_OFS_FLG1): return ISC_REG_FLG1;
            ADDR_W'(ISC_OFS_GEN): return ISC_REG_GEN;
            default: return ISC_REG_NONE;
        endcase
    endfunction

    logic [31:0] en_w [2];
    logic [31:0] flags_w [2];
    logic irq_w [2];
    logic [1:0] en_wr;
    logic do_wr;
    logic rd_take;
    isc_reg_t wr_reg;
    isc_reg_t rd_reg;
    logic [31:0] clr_vec;
    logic [31:0] src_vec;
    logic [31:0] custom_vec;

    // A write lands once both address and data are held
    assign do_wr = st.aw_held && st.w_held && !st.bvalid;
    assign wr_reg = decode(st.aw_addr);
    assign rd_reg = decode(s_axi_araddr_in);
    assign s_axi_awready_out = !st.aw_held && !st.bvalid;
    assign s_axi_wready_out = !st.w_held && !st.bvalid;
    assign s_axi_arready_out = !st.rvalid;
    assign rd_take = s_axi_arvalid_in && s_axi_arready_out;

    // only written ones on mapped bits clear
    always_comb begin
        clr_vec = 32'h0000_0000;
        if (do_wr && wr_reg == ISC_REG_CLR) begin
            clr_vec = st.w_data & isc_strb_mask(st.w_strb) & ISC_SRC_MASK;
        end
    end

    // custom events come from the sequencer port only
    always_comb begin
        custom_vec = 32'h0000_0000;
        if (seq_gen_wr_in) begin
            custom_vec[ISC_CUSTOM_LSB +: ISC_CUSTOM_N] = seq_gen_data_in;
        end
        src_vec = ((events_in & ~ISC_CUSTOM_MASK) | custom_vec) & ISC_SRC_MASK;
    end

    assign en_wr[0] = do_wr && wr_reg == ISC_REG_EN0;
    assign en_wr[1] = do_wr && wr_reg == ISC_REG_EN1;

    // shared polarity and clear, per-output enables
    for (genvar i = 0; i < 2; i++) begin : g_chan
        isc_irq_channel u_chan (
            .sys_clk_in(sys_clk_in),
            .rst_n_in(rst_n_in),
            .en_wr_in(en_wr[i]),
            .wr_data_in(st.w_data),
            .wr_strb_in(st.w_strb),
            .clr_in(clr_vec),
            .src_in(src_vec),
            .pol_in(st.pol),
            .enable_out(en_w[i]),
            .flags_out(flags_w[i]),
            .irq_out(irq_w[i])
        );
    end

    always_comb begin
        next_st = st;
        // Write address and data are taken in either order
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata_in;
            next_st.w_strb = s_axi_wstrb_in;
        end
        if (do_wr) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = (wr_reg == ISC_REG_NONE) ? ISC_RESP_SLVERR : ISC_RESP_OKAY;
            if (wr_reg == ISC_REG_POL && st.w_strb[0]) begin
                next_st.pol = st.w_data[ISC_POL_BIT];
            end
        end else if (st.bvalid && s_axi_bready_in) begin
            next_st.bvalid = 1'b0;
        end
        if (rd_take) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = ISC_RESP_OKAY;
            case (rd_reg)
                ISC_REG_POL: begin
                    next_st.rdata = {31'h0, st.pol};
                end
                ISC_REG_EN0: begin
                    next_st.rdata = en_w[0];
                end
                ISC_REG_EN1: begin
                    next_st.rdata = en_w[1];
                end
                ISC_REG_FLG0: begin
                    next_st.rdata = flags_w[0];
                end
                ISC_REG_FLG1: begin
                    next_st.rdata = flags_w[1];
                end
                ISC_REG_CLR: begin
                    next_st.rdata = ISC_CLR_RESET;
                end
                // Host view of the generation register stays empty
                ISC_REG_GEN: begin
                    next_st.rdata = 32'h0000_0000;
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = ISC_RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready_in) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st <= '{
                aw_held: 1'b0,
                aw_addr: '0,
                w_held: 1'b0,
                w_data: 32'h0000_0000,
                w_strb: 4'h0,
                bvalid: 1'b0,
                bresp: ISC_RESP_OKAY,
                rvalid: 1'b0,
                rdata: 32'h0000_0000,
                rresp: ISC_RESP_OKAY,
                pol: ISC_POL_RESET[ISC_POL_BIT]
            };
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_bvalid_out = st.bvalid;
    assign s_axi_bresp_out = st.bresp;
    assign s_axi_rvalid_out = st.rvalid;
    assign s_axi_rdata_out = st.rdata;
    assign s_axi_rresp_out = st.rresp;
    assign irq_output_0_out = irq_w[0];
    assign irq_output_1_out = irq_w[1];

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_read_of(isc_reg_t r);
        rd_take && rd_reg == r;
    endsequence

    AST_CLR_READS_ZERO: assert property (s_read_of(ISC_REG_CLR) |=>
        (s_axi_rvalid_out && s_axi_rdata_out == 32'h0000_0000))
        else $error("clear register read not zero");
    AST_POL_RESERVED: assert property (s_read_of(ISC_REG_POL) |=>
        (s_axi_rvalid_out && s_axi_rdata_out[31:1] == 31'h0))
        else $error("polarity reserved bits not zero");
    AST_POL_RESET: assert property ($rose(rst_n_in) |-> !st.pol)
        else $error("polarity not zero after reset");
    AST_HOST_GEN_IGNORED: assert property ((do_wr && wr_reg == ISC_REG_GEN
        && !seq_gen_wr_in && (events_in & ISC_CUSTOM_MASK) == 32'h0) |=>
        (((flags_w[0] | flags_w[1]) & ~$past(flags_w[0] | flags_w[1])
        & ISC_CUSTOM_MASK) == 32'h0))
        else $error("host write raised a custom flag");
    AST_WRITE_RESP: assert property ((st.aw_held && st.w_held && !st.bvalid) |=>
        s_axi_bvalid_out && !st.aw_held && !st.w_held)
        else $error("write response missing");
    AST_CUSTOM_SEQ: assert property ((seq_gen_wr_in && seq_gen_data_in[0]
        && en_w[0][ISC_CUSTOM_LSB]) |=> flags_w[0][ISC_CUSTOM_LSB])
        else $error("sequencer custom event lost");
    AST_CLR_ZERO_NOOP: assert property ((do_wr && wr_reg == ISC_REG_CLR
        && st.w_data == 32'h0000_0000) |-> clr_vec == 32'h0000_0000)
        else $error("zero write cleared a flag");

endmodule

// [tb/isc_host_mon.sv]
`timescale 1ns/10ps
module isc_host_mon (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic pol_in,
    input wire logic irq_in,
    output int edges_out
);
    logic last;
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            edges_out <= 0;
        end else if (irq_in != last && irq_in == pol_in) begin
            edges_out <= edges_out + 1;
        end
        last <= irq_in;
    end
endmodule

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench
    import isc_pkg::*;
;
    typedef struct {logic [15:0] a; logic [31:0] d; logic [31:0] e;} isc_row_t;
    logic clk, rst_n, gen_wr, awvalid, wvalid, arvalid, pol;
    logic awready, wready, bvalid, arready, rvalid, irq0, irq1;
    logic [3:0] gen_data;
    logic [15:0] awaddr, araddr;
    logic [31:0] events, wdata, rdata, exp;
    logic [1:0] bresp, rresp;
    int fail_count, check_count, edges0, edges1, base;
    isc_row_t rows [5] = '{'{ISC_OFS_POL, 32'hffff_ffff, 32'h0000_0001},
        '{ISC_OFS_POL, 32'h0000_0000, 32'h0000_0000},
        '{ISC_OFS_EN0, 32'hffff_ffff, 32'haf83_bfff},
        '{ISC_OFS_EN1, 32'h5a5a_5a5a, 32'h0a02_1a5a},
        '{ISC_OFS_CLR, 32'hffff_ffff, 32'h0000_0000}};

    isc_irq_ctrl uut (.sys_clk_in(clk), .rst_n_in(rst_n), .events_in(events),
        .seq_gen_wr_in(gen_wr), .seq_gen_data_in(gen_data),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(1'b1), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1),
        .irq_output_0_out(irq0), .irq_output_1_out(irq1));
    isc_host_mon mon0 (.sys_clk_in(clk), .rst_n_in(rst_n), .pol_in(pol), .irq_in(irq0),
        .edges_out(edges0));
    isc_host_mon mon1 (.sys_clk_in(clk), .rst_n_in(rst_n), .pol_in(pol), .irq_in(irq1),
        .edges_out(edges1));

    always #12.5 clk = ~clk;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic tmo(input int n);
        if (n >= 50) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, n, 0);
            end_sim();
        end
    endtask

    // Readies are sampled at the falling edge, where they are settled
    task automatic wrc(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw;
        n = 0;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw) && n < 50) begin
            @(negedge clk);
            ta = ta | awready;
            tw = tw | wready;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        tmo(n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        tmo(n);
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge clk);
    endtask

    task automatic rdc(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (arready !== 1'b1 && n < 50);
        tmo(n);
        @(posedge clk);
        arvalid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        tmo(n);
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge clk);
    endtask

    task automatic pulse(input logic [31:0] v, input logic g, input logic [3:0] gd);
        events <= v;
        gen_wr <= g;
        gen_data <= gd;
        @(posedge clk);
        events <= 32'h0000_0000;
        gen_wr <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        pol = 1'b0;
        events = 32'h0000_0000;
        gen_wr = 1'b0;
        gen_data = 4'h0;
        awaddr = 16'h0000;
        araddr = 16'h0000;
        wdata = 32'h0000_0000;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        fail_count = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            wrc(rows[i].a, rows[i].d, ISC_RESP_OKAY);
            rdc(rows[i].a, rows[i].e, ISC_RESP_OKAY);
        end
        $display("test rows done");
        wrc(ISC_OFS_EN1, 32'h0000_2000, ISC_RESP_OKAY);
        // Polarity writes in the rows moved the pins already
        base = edges0 + edges1;
        pulse(32'hffff_ffff, 1'b0, 4'h0);
        exp = ISC_SRC_MASK & ~ISC_CUSTOM_MASK;
        rdc(ISC_OFS_FLG0, exp, ISC_RESP_OKAY);
        rdc(ISC_OFS_FLG1, 32'h0000_2000, ISC_RESP_OKAY);
        chk(edges0 + edges1 - base, 2);
        wrc(ISC_OFS_CLR, 32'h5040_4000, ISC_RESP_OKAY);
        rdc(ISC_OFS_FLG0, exp, ISC_RESP_OKAY);
        for (int b = 0; b < 32; b++) begin
            if (exp[b]) begin
                wrc(ISC_OFS_CLR, 32'h1 << b, ISC_RESP_OKAY);
                exp[b] = 1'b0;
                rdc(ISC_OFS_FLG0, exp, ISC_RESP_OKAY);
            end
        end
        rdc(ISC_OFS_FLG1, 32'h0000_0000, ISC_RESP_OKAY);
        chk({31'h0, irq0}, 32'h1);
        $display("test clear done");
        wrc(ISC_OFS_GEN, 32'h0000_000f, ISC_RESP_OKAY);
        rdc(ISC_OFS_FLG0, 32'h0000_0000, ISC_RESP_OKAY);
        pulse(32'h0000_1e00, 1'b1, 4'h5);
        rdc(ISC_OFS_FLG0, 32'h0000_0a00, ISC_RESP_OKAY);
        rdc(ISC_OFS_FLG1, 32'h0000_0000, ISC_RESP_OKAY);
        wrc(ISC_OFS_CLR, 32'h0000_0200, ISC_RESP_OKAY);
        rdc(ISC_OFS_FLG0, 32'h0000_0800, ISC_RESP_OKAY);
        wrc(ISC_OFS_CLR, 32'h0000_0800, ISC_RESP_OKAY);
        $display("test custom done");
        pol <= 1'b1;
        wrc(ISC_OFS_POL, 32'h0000_0001, ISC_RESP_OKAY);
        base = edges0;
        pulse(32'h0000_0001, 1'b0, 4'h0);
        chk({31'h0, irq0}, 32'h1);
        @(negedge clk);
        chk(edges0 - base, 1);
        @(posedge clk);
        wrc(16'h3020, 32'hffff_ffff, ISC_RESP_SLVERR);
        rdc(16'h3020, 32'h0000_0000, ISC_RESP_SLVERR);
        wrc(ISC_OFS_FLG0, 32'h0000_0000, ISC_RESP_OKAY);
        rdc(ISC_OFS_FLG0, 32'h0000_0001, ISC_RESP_OKAY);
        $display("test polarity done");
        rst_n <= 1'b0;
        pol <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({31'h0, irq0}, 32'h1);
        rdc(ISC_OFS_POL, 32'h0000_0000, ISC_RESP_OKAY);
        rdc(ISC_OFS_EN0, 32'h0000_2000, ISC_RESP_OKAY);
        rdc(ISC_OFS_EN1, 32'h0000_2000, ISC_RESP_OKAY);
        rdc(ISC_OFS_CLR, 32'h0000_0000, ISC_RESP_OKAY);
        rdc(ISC_OFS_FLG0, 32'h0000_0000, ISC_RESP_OKAY);
        $display("test reset done");
        end_sim();
    end
endmodule
